// ==== common/lmdi_pkg.sv ====
// Constants and types for the limit monitor and diagnostic event block
package lmdi_pkg;
  // Channel count and clock rate
  localparam int NCH      = 4;
  localparam int CLK_HZ   = 40_000_000;
  localparam int US_PER_S = 1_000_000;
  // Cycles per microsecond, derived from the clock rate
  localparam int US_CYC   = CLK_HZ / US_PER_S;
  localparam logic [5:0] US_CYC_M1 = 6'(US_CYC - 1);

  // Limit encodings: these two values switch a limit off
  localparam logic [15:0] UL_OFF  = 16'h7FFF;
  localparam logic [15:0] LL_OFF  = 16'h8000;
  // Nominal range bounds, signed
  localparam logic [15:0] NOM_MAX = 16'h6C00;
  localparam logic [15:0] NOM_MIN = 16'h9400;

  // Record numbers and lengths
  localparam logic [7:0] REC_FULL      = 8'h01;
  localparam logic [7:0] REC_SHORT     = 8'h00;
  localparam logic [4:0] REC_LEN_FULL  = 5'h14;
  localparam logic [4:0] REC_LEN_SHORT = 5'h04;

  // Fixed record contents
  localparam logic [7:0] MOD_CLASS_INFO = 8'h15;
  localparam logic [7:0] CHAN_KIND      = 8'h71;
  localparam logic [7:0] DIAG_BITS      = 8'h08;
  localparam logic [7:0] CHAN_COUNT     = 8'h04;

  // Record byte positions
  localparam logic [4:0] RB_SUMMARY = 5'h00;
  localparam logic [4:0] RB_CLASS   = 5'h01;
  localparam logic [4:0] RB_RSVD_C  = 5'h02;
  localparam logic [4:0] RB_ERRD    = 5'h03;
  localparam logic [4:0] RB_KIND    = 5'h04;
  localparam logic [4:0] RB_NBITS   = 5'h05;
  localparam logic [4:0] RB_NCH     = 5'h06;
  localparam logic [4:0] RB_GROUP   = 5'h07;
  localparam logic [4:0] RB_CHANNEL_GROUP_ERRORS   = 5'h08;
  localparam logic [4:0] RB_STAMP   = 5'h10;

  // Summary byte bit positions
  localparam int SUM_MODFAIL = 0;
  localparam int SUM_INTERN  = 1;
  localparam int SUM_EXTERN  = 2;
  localparam int SUM_CHAN    = 3;
  localparam int SUM_AUX     = 4;
  localparam int SUM_PARAM   = 7;
  // Second diagnostic byte bit positions
  localparam int ED_BUFOVF = 3;
  localparam int ED_COMM   = 4;
  localparam int ED_PILOST = 6;
  // Channel error byte bit positions
  localparam int CE_PARAM  = 0;
  localparam int CE_PILOST = 5;
  localparam int CE_UNDER  = 6;
  localparam int CE_OVER   = 7;

  // Values after reset
  localparam logic [7:0]  RST_LIMIT_EN = 8'h00;
  localparam logic [7:0]  RST_DIAG_INTERRUPT_ENABLE  = 8'h00;
  localparam logic [31:0] RST_TICKER   = 32'h0000_0000;

  // Parameter set written by the controller
  typedef struct packed {
    logic [7:0]                limitEn;
    logic [7:0]                diagEn;
    logic [NCH-1:0][15:0]      upper;
    logic [NCH-1:0][15:0]      lower;
  } lmdi_param_t;

  // Measured values with range flags from the converter
  typedef struct packed {
    logic [NCH-1:0][15:0]      value;
    logic [NCH-1:0]            rangeOver;
    logic [NCH-1:0]            rangeUnder;
  } lmdi_meas_t;

  // Diagnostic record contents that change
  typedef struct packed {
    logic [7:0]                summary;
    logic [7:0]                errD;
    logic [NCH-1:0]            group;
    logic [NCH-1:0][7:0]       chanErr;
    logic [31:0]               stamp;
  } lmdi_diag_t;

  // Diagnostic interrupt state, Gray coded
  typedef enum logic [1:0] {
    DIAG_IDLE   = 2'h0,
    DIAG_ACTIVE = 2'h1
  } lmdi_dstate_t;
endpackage

// ==== verilog/limit_monitor_diag_interrupts.sv ====
// Limit monitor, process and diagnostic interrupt and record logic
`timescale 1ns/1ps

module limit_monitor_diag_interrupts (
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Parameter write strobe and data
  input  wire logic                paramWr,
  input  wire lmdi_pkg::lmdi_param_t paramIn,
  // Measured values and their strobe
  input  wire logic                measValid,
  input  wire lmdi_pkg::lmdi_meas_t  measIn,
  // Module-level fault inputs
  input  wire logic                auxSupplyMissing,
  input  wire logic                commError,
  input  wire logic                diagBufOverflow,
  // Link type and delivery acknowledge
  input  wire logic                linkIsCanopen,
  input  wire logic                procAck,
  // Record read request
  input  wire logic                recReq,
  input  wire logic [7:0]          recSel,
  input  wire logic [4:0]          recIdx,
  // Process interrupt outputs
  output logic                     procIrqEmergency,
  output logic                     procIrqDiag,
  output logic [7:0]               limitOverFlags,
  output logic [7:0]               limitUnderFlags,
  output logic [15:0]              eventTimestampLow,
  // Diagnostic interrupt outputs
  output logic                     diagIrqIncoming,
  output logic                     diagIrqGoing,
  output logic                     moduleFaultIndicator,
  output logic                     paramError,
  // Record read answer
  output logic                     recValid,
  output logic                     recError,
  output logic [7:0]               recData,
  // Microsecond ticker value
  output logic [31:0]              usTicker
);

  localparam int NCH = lmdi_pkg::NCH;

  // Whole module state in one record
  typedef struct packed {
    lmdi_pkg::lmdi_param_t  param;       // Stored parameters
    logic [5:0]             usDiv;       // Microsecond divider
    logic [31:0]            ticker;      // Microsecond ticker
    logic                   pending;     // Process interrupt undelivered
    logic                   viaEmerg;    // Deliver as emergency message
    logic [NCH-1:0]         overFlags;   // Captured overflow flags
    logic [NCH-1:0]         underFlags;  // Captured underflow flags
    logic [15:0]            stampLow;    // Captured timestamp
    logic                   lostAny;     // Some interrupt was lost
    logic [NCH-1:0]         lostCh;      // Lost, per channel
    logic [NCH-1:0]         chPErr;      // Limit setting error
    lmdi_pkg::lmdi_dstate_t dstate;      // Diagnostic state
    lmdi_pkg::lmdi_diag_t   snap;        // Frozen record
    logic                   incoming;    // Incoming pulse
    logic                   going;       // Going pulse
    logic                   faultInd;    // Fault indicator
    logic                   recValid;    // Answer strobe
    logic                   recErr;      // Answer is a refusal
    logic [7:0]             recData;     // Answer byte
    logic                   irqEm;       // Emergency route, registered
    logic                   irqDiag;     // Diagnostics route, registered
    logic                   pErrAny;     // Any limit error, registered
  } lmdi_state_t;

  lmdi_state_t s_q;                      // Registered state
  lmdi_state_t s_d;                      // Next state

  // Per-channel comparison results
  logic [NCH-1:0] pErr;                  // Limit outside nominal range
  logic [NCH-1:0] over;                  // Above upper limit
  logic [NCH-1:0] under;                 // Below lower limit
  logic [NCH-1:0][7:0] liveCh;           // Live channel error bytes

  // Per-channel limit checks
  for (genvar g = 0; g < NCH; g++) begin : gChan
    logic [15:0] up;
    logic [15:0] lo;
    logic        upOn;
    logic        loOn;
    logic        upNom;
    logic        loNom;
    assign up = s_q.param.upper[g];
    assign lo = s_q.param.lower[g];
    assign upOn = (up != lmdi_pkg::UL_OFF);
    assign loOn = (lo != lmdi_pkg::LL_OFF);
    // Nominal range test, signed
    assign upNom = ($signed(up) <= $signed(lmdi_pkg::NOM_MAX)) &&
                   ($signed(up) >= $signed(lmdi_pkg::NOM_MIN));
    assign loNom = ($signed(lo) <= $signed(lmdi_pkg::NOM_MAX)) &&
                   ($signed(lo) >= $signed(lmdi_pkg::NOM_MIN));
    assign pErr[g] = (upOn && !upNom) || (loOn && !loNom);
    assign over[g] = measValid && s_q.param.limitEn[g] && upOn &&
                     ($signed(measIn.value[g]) > $signed(up));
    assign under[g] = measValid && s_q.param.limitEn[g] && loOn &&
                      ($signed(measIn.value[g]) < $signed(lo));
    always_comb begin
      liveCh[g] = 8'h00;
      liveCh[g][lmdi_pkg::CE_PARAM]  = s_q.chPErr[g];
      liveCh[g][lmdi_pkg::CE_PILOST] = s_q.lostCh[g];
      liveCh[g][lmdi_pkg::CE_UNDER]  = measIn.rangeUnder[g];
      liveCh[g][lmdi_pkg::CE_OVER]   = measIn.rangeOver[g];
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    lmdi_pkg::lmdi_diag_t live;          // Record as it stands now
    lmdi_pkg::lmdi_diag_t src;           // Record shown to readers
    logic                 limEvt;        // Any limit crossing
    logic                 cond;          // Any diagnostic cause
    logic [4:0]           len;           // Length of selected record
    logic [7:0]           b;             // Selected record byte
    live   = '0;
    src    = '0;
    limEvt = |(over | under);
    cond   = 1'b0;
    len    = 5'h00;
    b      = 8'h00;
    s_d    = s_q;
    // Pulses last one cycle
    s_d.incoming = 1'b0;
    s_d.going    = 1'b0;
    s_d.recValid = 1'b0;
    s_d.recErr   = 1'b0;

    if (s_q.usDiv == lmdi_pkg::US_CYC_M1) begin
      s_d.usDiv  = 6'h00;
      // Natural 32-bit wrap returns to zero
      s_d.ticker = s_q.ticker + 32'h0000_0001;
    end else begin
      s_d.usDiv = s_q.usDiv + 6'h01;
    end

    // Parameter write takes effect next cycle
    if (paramWr) begin
      s_d.param = paramIn;
    end
    s_d.chPErr = pErr;

    // Full record read clears lost flags
    if (recReq && recSel == lmdi_pkg::REC_FULL) begin
      s_d.lostAny = 1'b0;
      s_d.lostCh  = '0;
    end

    // Controller took the process interrupt
    if (procAck) begin
      s_d.pending = 1'b0;
    end

    if (limEvt) begin
      if (s_q.pending && !procAck) begin
        // lost when undelivered
        // Set after clear, so a new loss wins
        s_d.lostAny = 1'b1;
        s_d.lostCh  = s_d.lostCh | over | under;
      end else begin
        s_d.pending    = 1'b1;
        s_d.overFlags  = over;
        s_d.underFlags = under;
        s_d.stampLow   = s_q.ticker[15:0];
        s_d.viaEmerg   = linkIsCanopen;
      end
    end

    // Live record contents
    live.chanErr = liveCh;
    for (int i = 0; i < NCH; i++) begin
      live.group[i] = |liveCh[i];
    end
    live.errD[lmdi_pkg::ED_BUFOVF] = diagBufOverflow;
    live.errD[lmdi_pkg::ED_COMM]   = commError;
    live.errD[lmdi_pkg::ED_PILOST] = s_q.lostAny;
    live.summary[lmdi_pkg::SUM_PARAM]  = |s_q.chPErr;
    live.summary[lmdi_pkg::SUM_AUX]    = auxSupplyMissing;
    live.summary[lmdi_pkg::SUM_CHAN]   = |live.group;
    live.summary[lmdi_pkg::SUM_EXTERN] = auxSupplyMissing |
        (|measIn.rangeOver) | (|measIn.rangeUnder);
    live.summary[lmdi_pkg::SUM_INTERN] = commError | diagBufOverflow |
        s_q.lostAny;
    live.summary[lmdi_pkg::SUM_MODFAIL] = (|live.group) |
        (|live.errD) | auxSupplyMissing;
    live.stamp = s_q.ticker;
    cond = |live.summary;

    // Diagnostic interrupt sequencing
    unique case (s_q.dstate)
      lmdi_pkg::DIAG_IDLE: begin
        if (cond && s_q.param.diagEn != 8'h00) begin
          s_d.dstate   = lmdi_pkg::DIAG_ACTIVE;
          s_d.incoming = 1'b1;
          s_d.snap     = live;
        end
      end
      lmdi_pkg::DIAG_ACTIVE: begin
        if (!cond) begin
          s_d.dstate = lmdi_pkg::DIAG_IDLE;
          s_d.going  = 1'b1;
        end
      end
      default: begin
        // Illegal code returns to idle
        s_d.dstate = lmdi_pkg::DIAG_IDLE;
      end
    endcase
    s_d.faultInd = (s_d.dstate == lmdi_pkg::DIAG_ACTIVE);

    // Readers see the frozen record while active
    src = (s_q.dstate == lmdi_pkg::DIAG_ACTIVE) ? s_q.snap : live;

    unique case (recIdx)
      lmdi_pkg::RB_SUMMARY: b = src.summary;
      lmdi_pkg::RB_CLASS:   b = lmdi_pkg::MOD_CLASS_INFO;
      lmdi_pkg::RB_RSVD_C:  b = 8'h00;
      lmdi_pkg::RB_ERRD:    b = src.errD;
      lmdi_pkg::RB_KIND:    b = lmdi_pkg::CHAN_KIND;
      lmdi_pkg::RB_NBITS:   b = lmdi_pkg::DIAG_BITS;
      lmdi_pkg::RB_NCH:     b = lmdi_pkg::CHAN_COUNT;
      lmdi_pkg::RB_GROUP:   b = {4'h0, src.group};
      default: begin
        // Channel bytes, reserved gap, then ticker LSB first
        if (recIdx[4:2] == lmdi_pkg::RB_CHANNEL_GROUP_ERRORS[4:2]) begin
          b = src.chanErr[recIdx[1:0]];
        end else if (recIdx[4:2] == lmdi_pkg::RB_STAMP[4:2]) begin
          b = src.stamp[8*recIdx[1:0] +: 8];
        end else begin
          b = 8'h00;
        end
      end
    endcase

    if (recSel == lmdi_pkg::REC_FULL) begin
      len = lmdi_pkg::REC_LEN_FULL;
    end else if (recSel == lmdi_pkg::REC_SHORT) begin
      len = lmdi_pkg::REC_LEN_SHORT;
    end else begin
      len = 5'h00;
    end
    // Answer one cycle after the request
    if (recReq) begin
      s_d.recValid = 1'b1;
      if (recIdx >= len) begin
        // Unknown record or index past its end
        s_d.recErr  = 1'b1;
        s_d.recData = 8'h00;
      end else begin
        s_d.recData = b;
      end
    end
    // Output copies kept as flops so no gate sits behind a port;
    // irqEm and irqDiag built from next state so they move on the same edge as before; pErrAny from pErr, a cycle behind
    s_d.irqEm   = s_d.pending && s_d.viaEmerg;
    s_d.irqDiag = s_d.pending && !s_d.viaEmerg;
    s_d.pErrAny = |pErr;
  end

  // State register; synchronous reset to constants only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q              <= '0;
      s_q.param.limitEn <= lmdi_pkg::RST_LIMIT_EN;
      s_q.param.diagEn <= lmdi_pkg::RST_DIAG_INTERRUPT_ENABLE;
      // Limits start switched off
      for (int i = 0; i < NCH; i++) begin
        s_q.param.upper[i] <= lmdi_pkg::UL_OFF;
        s_q.param.lower[i] <= lmdi_pkg::LL_OFF;
      end
      s_q.ticker       <= lmdi_pkg::RST_TICKER;
      s_q.dstate       <= lmdi_pkg::DIAG_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign procIrqEmergency     = s_q.irqEm;
  assign procIrqDiag          = s_q.irqDiag;
  assign limitOverFlags       = {4'h0, s_q.overFlags};
  assign limitUnderFlags      = {4'h0, s_q.underFlags};
  assign eventTimestampLow    = s_q.stampLow;
  assign diagIrqIncoming      = s_q.incoming;
  assign diagIrqGoing         = s_q.going;
  assign moduleFaultIndicator = s_q.faultInd;
  assign paramError           = s_q.pErrAny;
  assign recValid             = s_q.recValid;
  assign recError             = s_q.recErr;
  assign recData              = s_q.recData;
  assign usTicker             = s_q.ticker;

endmodule

// ==== bench/lmdi_ctrl.sv ====
// Controller model: takes pending process interrupts after a delay
`timescale 1ns/1ps
module lmdi_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       irqEm,
  input  wire logic       irqDiag,
  input  wire logic [3:0] ackDelay,
  output logic            procAck
);
  logic [3:0] waitCnt;  // Cycles spent pending so far

  // Ack once after ackDelay cycles; pending drops a cycle after the
  // ack is taken, so a second ack is held off by the !procAck term
  always @(posedge clk) begin
    if (!rst_n || !(irqEm || irqDiag)) begin
      waitCnt <= 4'h0;
      procAck <= 1'b0;
    end else begin
      procAck <= !procAck && waitCnt == ackDelay;
      waitCnt <= (waitCnt == ackDelay) ? 4'h0 : waitCnt + 4'h1;
    end
  end
endmodule

// ==== bench/lmdi_sva.sv ====
// Port checks for the limit monitor and diagnostic block
`timescale 1ns/1ps
module lmdi_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        measValid,
  input wire logic        linkIsCanopen,
  input wire logic        procAck,
  input wire logic        recReq,
  input wire logic [7:0]  recSel,
  input wire logic [4:0]  recIdx,
  input wire logic        procIrqEmergency,
  input wire logic        procIrqDiag,
  input wire logic [7:0]  limitOverFlags,
  input wire logic [7:0]  limitUnderFlags,
  input wire logic [15:0] eventTimestampLow,
  input wire logic        diagIrqIncoming,
  input wire logic        diagIrqGoing,
  input wire logic        moduleFaultIndicator,
  input wire logic        recValid,
  input wire logic        recError,
  input wire logic [7:0]  recData,
  input wire logic [31:0] usTicker
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pend;  // Either route counts as pending
  assign pend = procIrqEmergency || procIrqDiag;

  a_reserved_flags_zero: assert property (
    limitOverFlags[7:4] == 4'h0 && limitUnderFlags[7:4] == 4'h0)
    else $error("reserved limit flag bits set");
  a_link_route: assert property (
    $rose(pend) |-> procIrqEmergency == $past(linkIsCanopen))
    else $error("process interrupt on wrong route");
  a_event_needs_meas: assert property (
    $rose(pend) |-> $past(measValid))
    else $error("process interrupt without a measurement");
  a_stamp_capture: assert property (
    $rose(pend) |-> eventTimestampLow == $past(usTicker[15:0]))
    else $error("timestamp not taken at the event");
  a_pending_holds: assert property (
    pend && !procAck |=> pend)
    else $error("process interrupt dropped without ack");
  a_ticker_step: assert property (
    usTicker != $past(usTicker) |-> usTicker == $past(usTicker) + 32'h1)
    else $error("ticker jumped");
  a_incoming_lights: assert property (
    $rose(moduleFaultIndicator) |-> diagIrqIncoming)
    else $error("fault indicator lit without incoming");
  a_going_darkens: assert property (
    diagIrqGoing |-> !moduleFaultIndicator && $past(moduleFaultIndicator))
    else $error("going pulse outside active window");
  a_rec_answer: assert property (
    recReq |=> recValid)
    else $error("record answer missing");
  a_rec_short_len: assert property (
    recReq && recSel == 8'h00 && recIdx >= 5'h04 |=>
      recError && recData == 8'h00)
    else $error("short record read past its length");

  c_event: cover property ($rose(pend));
  c_going: cover property (diagIrqGoing);
  c_rec_err: cover property (recValid && recError);
endmodule

bind limit_monitor_diag_interrupts lmdi_sva lmdi_sva_i (
  .clk(clk), .rst_n(rst_n), .measValid(measValid),
  .linkIsCanopen(linkIsCanopen), .procAck(procAck), .recReq(recReq),
  .recSel(recSel), .recIdx(recIdx), .procIrqEmergency(procIrqEmergency),
  .procIrqDiag(procIrqDiag), .limitOverFlags(limitOverFlags),
  .limitUnderFlags(limitUnderFlags), .eventTimestampLow(eventTimestampLow),
  .diagIrqIncoming(diagIrqIncoming), .diagIrqGoing(diagIrqGoing),
  .moduleFaultIndicator(moduleFaultIndicator), .recValid(recValid),
  .recError(recError), .recData(recData), .usTicker(usTicker)
);

// ==== bench/tb.sv ====
// Self-checking bench for the limit monitor and diagnostic block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, paramWr = 1'b0, measValid = 1'b0;
  logic auxSupplyMissing = 1'b0, commError = 1'b0, diagBufOverflow = 1'b0;
  logic linkIsCanopen = 1'b0, recReq = 1'b0, procAck;
  logic [7:0]  recSel = 8'h00;
  logic [4:0]  recIdx = 5'h00;
  logic [3:0]  ackDelay = 4'h0;
  lmdi_pkg::lmdi_param_t paramIn, pv;
  lmdi_pkg::lmdi_meas_t  measIn = '0;
  logic procIrqEmergency, procIrqDiag, diagIrqIncoming, diagIrqGoing;
  logic moduleFaultIndicator, paramError, recValid, recError;
  logic [7:0]  limitOverFlags, limitUnderFlags, recData;
  logic [15:0] eventTimestampLow, ts;
  logic [31:0] usTicker;
  int nFail = 0, cmpCount = 0, nInc = 0, nGo = 0;
  // Record table: select, index, data, error
  logic [31:0] tab[12] = '{32'h0100_0000, 32'h0101_1500, 32'h0102_0000,
    32'h0104_7100, 32'h0105_0800, 32'h0106_0400, 32'h010C_0000,
    32'h0113_0000, 32'h0114_0001, 32'h0003_0000, 32'h0004_0001,
    32'h0200_0001};

  always #12.5 clk = ~clk;

  limit_monitor_diag_interrupts limit_monitor_diag_interrupts_i (
    .clk, .rst_n, .paramWr, .paramIn, .measValid, .measIn,
    .auxSupplyMissing, .commError, .diagBufOverflow, .linkIsCanopen,
    .procAck, .recReq, .recSel, .recIdx, .procIrqEmergency, .procIrqDiag,
    .limitOverFlags, .limitUnderFlags, .eventTimestampLow,
    .diagIrqIncoming, .diagIrqGoing, .moduleFaultIndicator, .paramError,
    .recValid, .recError, .recData, .usTicker);
  lmdi_ctrl lmdi_ctrl_i (.clk, .rst_n, .irqEm(procIrqEmergency),
    .irqDiag(procIrqDiag), .ackDelay, .procAck);

  // Pulse counters, so tests need not hit the exact cycle
  always @(posedge clk) begin
    nInc += int'(diagIrqIncoming === 1'b1);
    nGo += int'(diagIrqGoing === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wp(input lmdi_pkg::lmdi_param_t p);
    @(posedge clk);
    paramWr <= 1'b1;
    paramIn <= p;
    @(posedge clk);
    paramWr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // One-cycle measurement; ts keeps the ticker seen at the taking edge
  task automatic ms(input logic [15:0] v0, v1, v2, v3);
    @(posedge clk);
    measValid <= 1'b1;
    measIn.value <= {v3, v2, v1, v0};
    #1 ts = usTicker[15:0];
    @(posedge clk);
    measValid <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] sel, input logic [4:0] idx);
    @(posedge clk);
    recReq <= 1'b1;
    recSel <= sel;
    recIdx <= idx;
    @(posedge clk);
    recReq <= 1'b0;
    #1 chk(recValid, 1'b1);
  endtask

  task automatic t_record();
    chk(usTicker, 32'h0);
    for (int i = 0; i < 12; i++) begin
      rd(tab[i][31:24], tab[i][20:16]);
      chk(recData, tab[i][15:8]);
      chk(recError, tab[i][0]);
    end
    $display("record test done");
  endtask

  task automatic t_ticker();
    logic [31:0] v;
    v = usTicker;
    repeat (50) if (usTicker === v) begin
      @(posedge clk);
      #1;
    end
    v = usTicker;
    repeat (lmdi_pkg::US_CYC - 1) @(posedge clk);
    #1 chk(usTicker, v);
    @(posedge clk);
    #1 chk(usTicker, v + 32'h1);
    $display("ticker test done");
  endtask

  task automatic t_limits();
    pv.limitEn = 8'h07;
    pv.upper = {16'h0000, 16'h0010, 16'h7FFF, 16'h03E8};
    pv.lower = {16'h8000, 16'h8000, 16'hFC18, 16'h8000};
    wp(pv);
    // On the limits, a negative value and a masked channel
    ms(16'h03E8, 16'hFC18, 16'hFF00, 16'h0100);
    repeat (2) @(posedge clk);
    #1 chk(procIrqEmergency | procIrqDiag, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      linkIsCanopen <= k[0];
      ms(16'h03E9, 16'hFC17, 16'h0000, 16'h0000);
      chk(limitOverFlags, 8'h01);
      chk(limitUnderFlags, 8'h02);
      chk(eventTimestampLow, ts);
      chk(procIrqEmergency, k[0]);
      repeat (4) @(posedge clk);
      #1 chk(procIrqEmergency | procIrqDiag, 1'b0);
    end
    $display("limit test done");
  endtask

  // Slow controller: a second event while pending is lost
  task automatic t_lost();
    @(posedge clk);
    ackDelay <= 4'hF;
    ms(16'h03E9, 16'h0000, 16'h0000, 16'h0000);
    ms(16'h0000, 16'hFC17, 16'h0000, 16'h0000);
    chk(limitUnderFlags, 8'h00);
    rd(8'h00, 5'h03);
    chk(recData & 8'h40, 8'h40);
    rd(8'h01, 5'h09);
    chk(recData & 8'h20, 8'h20);
    rd(8'h01, 5'h03);
    chk(recData & 8'h40, 8'h00);
    @(posedge clk);
    ackDelay <= 4'h0;
    repeat (20) @(posedge clk);
    #1 chk(procIrqEmergency | procIrqDiag, 1'b0);
    $display("lost test done");
  endtask

  task automatic t_diag();
    @(posedge clk);
    commError <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(nInc, 0);
    pv.diagEn = 8'h01;
    wp(pv);
    // Faults arriving while active must not reach the record
    @(posedge clk);
    auxSupplyMissing <= 1'b1;
    diagBufOverflow <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(nInc, 1);
    chk(moduleFaultIndicator, 1'b1);
    rd(8'h01, 5'h03);
    chk(recData, 8'h10);
    rd(8'h01, 5'h00);
    chk(recData, 8'h03);
    @(posedge clk);
    commError <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(nGo, 0);
    @(posedge clk);
    auxSupplyMissing <= 1'b0;
    diagBufOverflow <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(nGo, 1);
    chk(moduleFaultIndicator, 1'b0);
    $display("diag test done");
  endtask

  task automatic t_param();
    pv.diagEn = 8'h00;
    pv.upper[0] = 16'h6C01;
    pv.lower[1] = 16'h93FF;
    wp(pv);
    chk(paramError, 1'b1);
    rd(8'h01, 5'h09);
    chk(recData & 8'h01, 8'h01);
    // Range flags on two channels show up live while no diag is active
    @(posedge clk);
    measIn.rangeOver <= 4'h4;
    measIn.rangeUnder <= 4'h8;
    rd(8'h01, 5'h0A);
    chk(recData, 8'h80);
    rd(8'h01, 5'h0B);
    chk(recData, 8'h40);
    rd(8'h01, 5'h07);
    chk(recData, 8'h0F);
    rd(8'h01, 5'h00);
    chk(recData, 8'h8D);
    @(posedge clk);
    measIn.rangeOver <= 4'h0;
    measIn.rangeUnder <= 4'h0;
    pv.upper[0] = 16'h6C00;
    pv.lower[1] = 16'h9400;
    wp(pv);
    // Other limits hold switch-off codes or in-range values; the codes lie outside nominal range
    chk(paramError, 1'b0);
    $display("param test done");
  endtask

  initial begin
    pv = '0;
    pv.upper = {4{16'h7FFF}};
    pv.lower = {4{16'h8000}};
    paramIn = pv;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_record();
    t_ticker();
    t_limits();
    t_lost();
    t_diag();
    t_param();
    finish_test();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    nFail++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
